// *** logic/bgc_pkg.sv ***
// Constants and types shared by the burst gate control block
// Behaviour
// - Continuous mode: every received bit counts unless mask mode holds aux low
// - Burst allowed for PRBS, zero-sub, data, mixed
// - Burst gate source: internal, trigger or enable
// - Internal source builds gate from window, cycle
// - Trigger: rising edge opens window of set length
// - Enable source: valid only while aux high
// - Mask mode: aux low suppresses measurement
// - Auto delay aligns gate to incoming pattern when frame sync is on
// - Single channel delay 0..2147483640, step 8
// - Two channel delay 0..4294967280, step 16
// - Four channel delay 0..8589934560, step 32
// - Single channel cycle 25600..2^31, step 256
// - Single channel window minimum 12800, source maxima
// - Two channel cycle 51200..2^32, step 512
// - Two channel window minimum 25600, source maxima
// - Four channel cycle 102400..2^33, step 1024
// - Four channel window minimum 51200, source maxima
package bgc_pkg;
   // Channel combination; also log2 of the channel count
   typedef enum logic [1:0] {BGC_CH1, BGC_CH2, BGC_CH4} bgc_comb_t;
   typedef enum logic [1:0] {BGC_SRC_INT, BGC_SRC_TRIG, BGC_SRC_EN} bgc_src_t;
   typedef enum logic [1:0] {BGC_AUX_OFF, BGC_AUX_BURST, BGC_AUX_MASK} bgc_aux_t;
   typedef enum logic [2:0] {BGC_PAT_PRBS, BGC_PAT_ZSUB, BGC_PAT_DATA, BGC_PAT_MIXED,
      BGC_PAT_OTHER} bgc_pat_t;
   // Received data arrives 8 bits a clock per channel
   localparam int BGC_DW = 32;
   // Counts are in words of the delay step (8/16/32 bits)
   localparam int BGC_DLY_W = 28;
   localparam logic [27:0] BGC_DLY_MAX = 28'hfffffff;
   // Cycle and window are in 256/512/1024-bit units
   localparam int BGC_LEN_W = 24;
   localparam logic [23:0] BGC_CYC_MIN = 24'h000064;
   localparam logic [23:0] BGC_CYC_MAX = 24'h800000;
   localparam logic [23:0] BGC_WIN_MIN = 24'h000032;
   localparam logic [23:0] BGC_WIN_MAX_INT = 24'h7ffffc;
   localparam logic [23:0] BGC_WIN_MAX_TRG = 24'h7fffff;
   // Least gap of 512 bits per channel = 2 length units
   localparam logic [23:0] BGC_GAP_MIN = 24'h000002;
   // Words of delay step per length unit: 256/8
   localparam int BGC_UNIT_SH = 5;
   // Auto delay: start of the aligner wait count; it counts accepted words down to 0 and the aligner keeps waiting
   localparam logic [7:0] BGC_ALIGN_WAIT = 8'hff;
   localparam int BGC_SYNC_STAGES = 2;
   // Buffer depth (two entries)
   localparam int BGC_BUF_DEPTH = 2;
endpackage

// *** logic/bgc_skid_buf.sv ***
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/100ps
module bgc_skid_buf
   import bgc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [BGC_DW:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [BGC_DW:0] out_data
);
   logic [BGC_DW:0] mem_r [BGC_BUF_DEPTH];
   logic [BGC_DW:0] mem_nxt [BGC_BUF_DEPTH];
   logic wp_r, wp_nxt, rp_r, rp_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic push, pop;

   // Honest full and empty flags off the occupancy count
   assign in_ready = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data = mem_r[rp_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Next pointers and storage
   always_comb begin
      mem_nxt = mem_r;
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      cnt_nxt = cnt_r;
      if (push) begin
         mem_nxt[wp_r] = in_data;
         wp_nxt = ~wp_r;
      end
      if (pop) begin
         rp_nxt = ~rp_r;
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + 2'h1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 2'h1;
      end
   end

   // Register stage
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_r[0] <= '0;
         mem_r[1] <= '0;
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         cnt_r <= 2'h0;
      end else begin
         mem_r <= mem_nxt;
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end
endmodule

// *** logic/bgc_gate.sv ***
// Burst gate control: decides which received words count for errors
`timescale 1ns/100ps
module bgc_gate
   import bgc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Configuration
   input wire logic burst_mode,
   input wire bgc_src_t gate_src,
   input wire bgc_aux_t aux_func,
   input wire bgc_comb_t comb,
   input wire bgc_pat_t pat_type,
   input wire logic delay_auto,
   input wire logic frame_sync_on,
   input wire logic [BGC_DLY_W-1:0] delay_words,
   input wire logic [BGC_LEN_W-1:0] window_len,
   input wire logic [BGC_LEN_W-1:0] cycle_len,
   // Auxiliary input and pattern alignment marker
   input wire logic aux_in,
   input wire logic pat_start,
   // Received data stream in
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic [BGC_DW-1:0] rx_err,
   // Gated stream out to the error counters
   output logic cnt_valid,
   input wire logic cnt_ready,
   output logic [BGC_DW-1:0] cnt_err,
   output logic cnt_gate,
   // Status
   output logic cfg_error,
   output logic align_done,
   output logic gate_open
);
   // Range check: is a length in bounds for this source
   function automatic logic len_ok(input logic [BGC_LEN_W-1:0] win,
         input logic [BGC_LEN_W-1:0] cyc, input bgc_src_t src);
      logic ok;
      // Lengths are in per-channel units, so one bound set serves all combinations
      ok = (win >= BGC_WIN_MIN);
      if (src == BGC_SRC_INT) begin
         ok = ok && (win <= BGC_WIN_MAX_INT) && (cyc >= BGC_CYC_MIN)
            && (cyc <= BGC_CYC_MAX);
         ok = ok && (cyc >= win + BGC_GAP_MIN);
      end else if (src == BGC_SRC_TRIG) begin
         ok = ok && (win <= BGC_WIN_MAX_TRG);
      end
      return ok;
   endfunction

   // Units are per channel; the step scales with combination so fields stay equal
   logic [BGC_DLY_W-1:0] word_shift;
   logic aux_s1_r, aux_s2_r, aux_d_r;
   logic [BGC_DLY_W-1:0] dly_cnt_r, dly_cnt_nxt;
   logic [BGC_DLY_W+BGC_UNIT_SH-1:0] win_cnt_r, win_cnt_nxt, cyc_cnt_r, cyc_cnt_nxt;
   logic [BGC_DLY_W+BGC_UNIT_SH-1:0] win_words, cyc_words;
   logic [7:0] wait_r, wait_nxt;
   logic pat_ok, cfg_ok, aux_rise, step, gate_win, meas;

   typedef enum logic [1:0] {ST_IDLE, ST_ALIGN, ST_DELAY, ST_RUN} bgc_st_t;
   bgc_st_t st_r, st_nxt;
   logic align_r, align_nxt, gate_r, gate_nxt;

   // Two-flop synchroniser; only the second stage is looked at
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         aux_s1_r <= 1'b0;
         aux_s2_r <= 1'b0;
         aux_d_r <= 1'b0;
      end else begin
         aux_s1_r <= aux_in;
         aux_s2_r <= aux_s1_r;
         aux_d_r <= aux_s2_r;
      end
   end

   assign aux_rise = aux_s2_r && !aux_d_r;
   assign step = rx_valid && rx_ready;
   assign win_words = {{(BGC_DLY_W-BGC_LEN_W){1'b0}}, window_len, {BGC_UNIT_SH{1'b0}}};
   assign cyc_words = {{(BGC_DLY_W-BGC_LEN_W){1'b0}}, cycle_len, {BGC_UNIT_SH{1'b0}}};
   assign word_shift = delay_words;
   // Burst only for these pattern families
   assign pat_ok = (pat_type != BGC_PAT_OTHER);
   assign cfg_ok = len_ok(window_len, cycle_len, gate_src);
   assign cfg_error = burst_mode && (!pat_ok || (gate_src != BGC_SRC_EN && !cfg_ok));
   assign align_done = align_r;

   // Gate sequencer: alignment, delay, then run of window/cycle counters
   always_comb begin
      st_nxt = st_r;
      dly_cnt_nxt = dly_cnt_r;
      win_cnt_nxt = win_cnt_r;
      cyc_cnt_nxt = cyc_cnt_r;
      wait_nxt = wait_r;
      align_nxt = align_r;
      gate_nxt = gate_r;
      if (!burst_mode || cfg_error || gate_src == BGC_SRC_EN) begin
         st_nxt = ST_IDLE;
         gate_nxt = 1'b0;
         align_nxt = 1'b0;
      end else begin
         unique case (st_r)
            ST_IDLE: begin
               wait_nxt = BGC_ALIGN_WAIT;
               st_nxt = delay_auto ? ST_ALIGN : ST_DELAY;
               dly_cnt_nxt = delay_auto ? '0 : word_shift;
            end
            ST_ALIGN: begin
               // Auto delay locks onto the pattern marker; needs frame sync
               if (!delay_auto) begin
                  st_nxt = ST_IDLE;
               end else if (frame_sync_on && step && pat_start) begin
                  align_nxt = 1'b1;
                  st_nxt = ST_DELAY;
               end else if (step && wait_r != 8'h00) begin
                  wait_nxt = wait_r - 8'h01;
               end
            end
            ST_DELAY: begin
               if (step) begin
                  if (dly_cnt_r == '0) begin
                     if (gate_src == BGC_SRC_INT) begin
                        st_nxt = ST_RUN;
                        gate_nxt = 1'b1;
                        win_cnt_nxt = win_words - 1'b1;
                        cyc_cnt_nxt = cyc_words - 1'b1;
                     end else if (aux_rise) begin
                        st_nxt = ST_RUN;
                        gate_nxt = 1'b1;
                        win_cnt_nxt = win_words - 1'b1;
                     end
                  end else begin
                     dly_cnt_nxt = dly_cnt_r - 1'b1;
                  end
               end
            end
            ST_RUN: begin
               if (step) begin
                  if (win_cnt_r != '0) begin
                     win_cnt_nxt = win_cnt_r - 1'b1;
                  end else begin
                     gate_nxt = 1'b0;
                  end
                  if (gate_src == BGC_SRC_INT) begin
                     if (cyc_cnt_r == '0) begin
                        gate_nxt = 1'b1;
                        win_cnt_nxt = win_words - 1'b1;
                        cyc_cnt_nxt = cyc_words - 1'b1;
                     end else begin
                        cyc_cnt_nxt = cyc_cnt_r - 1'b1;
                     end
                  end else if (win_cnt_r == '0) begin
                     // Trigger window closed: rearm on the next edge
                     st_nxt = ST_DELAY;
                     dly_cnt_nxt = delay_auto ? '0 : word_shift;
                  end
               end
               if (delay_auto && !align_r) begin
                  st_nxt = ST_IDLE;
               end
            end
            default: st_nxt = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= ST_IDLE;
         dly_cnt_r <= '0;
         win_cnt_r <= '0;
         cyc_cnt_r <= '0;
         wait_r <= 8'h00;
         align_r <= 1'b0;
         gate_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         dly_cnt_r <= dly_cnt_nxt;
         win_cnt_r <= win_cnt_nxt;
         cyc_cnt_r <= cyc_cnt_nxt;
         wait_r <= wait_nxt;
         align_r <= align_nxt;
         gate_r <= gate_nxt;
      end
   end

   // Window per source; continuous mode always open
   always_comb begin
      if (!burst_mode) begin
         gate_win = 1'b1;
      end else if (cfg_error) begin
         gate_win = 1'b0;
      end else if (gate_src == BGC_SRC_EN) begin
         gate_win = aux_s2_r;
      end else begin
         gate_win = gate_r;
      end
   end

   // Mask mode: low aux blocks counting regardless of window
   assign meas = gate_win && !(aux_func == BGC_AUX_MASK && !aux_s2_r);
   assign gate_open = meas;

   // Buffer keeps words when the counters stall; gate flag rides with the data
   bgc_skid_buf u_buf (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .in_valid(rx_valid),
      .in_ready(rx_ready),
      .in_data({meas, rx_err}),
      .out_valid(cnt_valid),
      .out_ready(cnt_ready),
      .out_data({cnt_gate, cnt_err})
   );
   // Counters must ignore cnt_err when cnt_gate is low
   // not enforced here: cnt_err passes unmasked, only the cnt_gate flag marks it
endmodule

// *** sim/bgc_aux_model.sv ***
// Auxiliary timing source standing in front of the gate block
`timescale 1ns/100ps
module bgc_aux_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Requests from the bench
   input wire logic lvl_req,
   input wire logic trig_req,
   // Auxiliary line
   output logic aux_out
);
   logic [2:0] pulse_r, pulse_nxt;
   // A trigger is a short high pulse; its rising edge is what counts
   always_comb begin
      pulse_nxt = pulse_r;
      if (trig_req) pulse_nxt = 3'h4;
      else if (pulse_r != 3'h0) pulse_nxt = pulse_r - 3'h1;
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) pulse_r <= 3'h0;
      else pulse_r <= pulse_nxt;
   end
   // Level is held for the whole valid period
   assign aux_out = lvl_req | (pulse_r != 3'h0);
endmodule

// *** sim/bgc_gate_asserts.sv ***
// Port-level checks of the burst gate block
`timescale 1ns/100ps
module bgc_gate_asserts
   import bgc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic burst_mode,
   input wire bgc_src_t gate_src,
   input wire bgc_aux_t aux_func,
   input wire bgc_pat_t pat_type,
   input wire logic aux_in,
   input wire logic rx_valid,
   input wire logic rx_ready,
   input wire logic cnt_valid,
   input wire logic cnt_ready,
   input wire logic [BGC_DW-1:0] cnt_err,
   input wire logic cnt_gate,
   input wire logic cfg_error,
   input wire logic gate_open
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_out_hold_stall: assert property (cnt_valid && !cnt_ready |=> cnt_valid && $stable(cnt_err)
      && $stable(cnt_gate)) else $error("output word changed while stalled");
   a_take_gives_out: assert property (rx_valid && rx_ready |=> cnt_valid)
      else $error("accepted word not presented");
   a_full_means_out: assert property (!rx_ready |-> cnt_valid)
      else $error("refusing with empty output");
   a_cont_all_count: assert property (!burst_mode && aux_func == BGC_AUX_OFF |-> gate_open)
      else $error("continuous mode gate closed");
   a_pat_other_err: assert property (burst_mode && pat_type == BGC_PAT_OTHER |-> cfg_error)
      else $error("unsupported pattern not flagged");
   a_cfg_err_close: assert property (burst_mode && cfg_error && gate_src != BGC_SRC_EN
      |-> !gate_open) else $error("gate open with bad settings");
   a_mask_low_shut: assert property (aux_func == BGC_AUX_MASK && !aux_in [*4]
      |-> !gate_open) else $error("masked word counted");
   a_en_low_shut: assert property (burst_mode && gate_src == BGC_SRC_EN
      && aux_func == BGC_AUX_BURST && !aux_in [*4] |-> !gate_open)
      else $error("enable low but gate open");
endmodule
bind bgc_gate bgc_gate_asserts u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
   .burst_mode(burst_mode), .gate_src(gate_src), .aux_func(aux_func), .pat_type(pat_type),
   .aux_in(aux_in), .rx_valid(rx_valid), .rx_ready(rx_ready), .cnt_valid(cnt_valid),
   .cnt_ready(cnt_ready), .cnt_err(cnt_err), .cnt_gate(cnt_gate), .cfg_error(cfg_error),
   .gate_open(gate_open));

// *** sim/tb_bgc_gate.sv ***
// Self-checking bench of the burst gate block
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
   $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_bgc_gate;
   import bgc_pkg::*;
   typedef struct {bgc_pat_t pat; logic [23:0] win; logic err;} bgc_row_t;
   logic sys_clk = 1'b0, rst_n = 1'b0, burst_mode = 1'b0, delay_auto = 1'b0;
   logic frame_sync_on = 1'b0, pat_start = 1'b0, rx_valid = 1'b0, cnt_ready = 1'b1;
   logic lvl_req = 1'b0, trig_req = 1'b0, aux_in, rx_ready, cnt_valid, cnt_gate;
   logic cfg_error, align_done, gate_open;
   bgc_src_t gate_src = BGC_SRC_INT;
   bgc_aux_t aux_func = BGC_AUX_OFF;
   bgc_pat_t pat_type = BGC_PAT_PRBS;
   logic [23:0] window_len = 24'h000032, cycle_len = 24'h000064;
   logic [31:0] rx_err = 32'h0, cnt_err;
   int fail_count = 0, samples_checked = 0, cyc = 0, ones, i;
   bgc_row_t rows [8] = '{'{BGC_PAT_PRBS, 24'h32, 1'b0}, '{BGC_PAT_ZSUB, 24'h32, 1'b0},
      '{BGC_PAT_DATA, 24'h32, 1'b0}, '{BGC_PAT_MIXED, 24'h32, 1'b0},
      '{BGC_PAT_OTHER, 24'h32, 1'b1}, '{BGC_PAT_PRBS, 24'h31, 1'b1},
      '{BGC_PAT_PRBS, 24'h7ffffd, 1'b1}, '{BGC_PAT_PRBS, 24'h63, 1'b1}};
   bgc_gate DUT (.sys_clk(sys_clk), .rst_n(rst_n), .burst_mode(burst_mode),
      .gate_src(gate_src), .aux_func(aux_func), .comb(BGC_CH1), .pat_type(pat_type),
      .delay_auto(delay_auto), .frame_sync_on(frame_sync_on), .delay_words(28'h0),
      .window_len(window_len), .cycle_len(cycle_len), .aux_in(aux_in),
      .pat_start(pat_start), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_err(rx_err),
      .cnt_valid(cnt_valid), .cnt_ready(cnt_ready), .cnt_err(cnt_err),
      .cnt_gate(cnt_gate), .cfg_error(cfg_error), .align_done(align_done),
      .gate_open(gate_open));
   bgc_aux_model u_aux (.sys_clk(sys_clk), .rst_n(rst_n), .lvl_req(lvl_req),
      .trig_req(trig_req), .aux_out(aux_in));
   // 50 MHz clock
   always #10 sys_clk = ~sys_clk;
   // Hang guard: all scenarios together take well under this
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Stream n words numbered from 0, count the ones that are gated in
   task automatic stream(input int n, output int cnt);
      int sent, got;
      sent = 0;
      got = 0;
      cnt = 0;
      rx_err <= 32'h0;
      rx_valid <= 1'b1;
      while (got < n) begin
         @(posedge sys_clk);
         if (rx_valid && rx_ready) begin
            sent++;
            rx_err <= 32'(sent);
            if (sent >= n) rx_valid <= 1'b0;
         end
         if (cnt_valid && cnt_ready) begin
            `CHK(cnt_err, 32'(got))
            got++;
            cnt += int'(cnt_gate);
         end
      end
      @(posedge sys_clk);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   initial begin
      settle(10);
      rst_n <= 1'b1;
      settle(2);
      stream(20, ones);
      `CHK(ones, 20)
      // Configuration rows in burst mode with the internal source
      burst_mode <= 1'b1;
      // Last row leaves too short a gap before the next cycle
      for (i = 0; i < 8; i++) begin
         pat_type <= rows[i].pat;
         window_len <= rows[i].win;
         settle(2);
         `CHK(cfg_error, rows[i].err)
      end
      pat_type <= BGC_PAT_PRBS;
      window_len <= 24'h000032;
      // Internal gate: any 3200 consecutive words hold 1600 valid ones
      stream(200, ones);
      stream(3200, ones);
      `CHK(ones, 1600)
      // Stall: the buffer takes two words, then refuses, and loses none
      cnt_ready <= 1'b0;
      rx_valid <= 1'b1;
      settle(4);
      `CHK(rx_ready, 1'b0)
      `CHK(cnt_valid, 1'b1)
      rx_valid <= 1'b0;
      cnt_ready <= 1'b1;
      settle(4);
      `CHK(cnt_valid, 1'b0)
      // Enable source follows the synchronised level; the one for uneven bursts
      gate_src <= BGC_SRC_EN;
      aux_func <= BGC_AUX_BURST;
      lvl_req <= 1'b1;
      settle(6);
      stream(16, ones);
      `CHK(ones, 16)
      lvl_req <= 1'b0;
      settle(6);
      stream(16, ones);
      `CHK(ones, 0)
      // Trigger opens a window of 1600 words from the rising edge
      gate_src <= BGC_SRC_TRIG;
      fork
         stream(1800, ones);
         begin
            settle(30);
            trig_req <= 1'b1;
            settle(1);
            trig_req <= 1'b0;
         end
      join
      `CHK(ones, 1600)
      // Mask: a low level suppresses counting even in continuous mode
      burst_mode <= 1'b0;
      aux_func <= BGC_AUX_MASK;
      settle(6);
      stream(16, ones);
      `CHK(ones, 0)
      lvl_req <= 1'b1;
      settle(6);
      stream(16, ones);
      `CHK(ones, 16)
      // Automatic delay aligns on the pattern head with frame sync on
      burst_mode <= 1'b1;
      gate_src <= BGC_SRC_INT;
      aux_func <= BGC_AUX_OFF;
      frame_sync_on <= 1'b1;
      delay_auto <= 1'b1;
      pat_start <= 1'b1;
      stream(16, ones);
      `CHK(align_done, 1'b1)
      stop_test();
   end
endmodule
